// >>> src/hscp_defs.vh
// shared constants for the host serial command port
`ifndef HSCP_DEFS_VH
`define HSCP_DEFS_VH

// lane-width codes
`define HSCP_WIDTH_ONE 2'b00
`define HSCP_WIDTH_TWO 2'b01
`define HSCP_WIDTH_FOUR 2'b10
`define HSCP_WIDTH_RSVD 2'b11
`define HSCP_LANE_WIDTH_RST 2'b00

// lane output-enable masks per width
`define HSCP_OE_NONE 4'h0
`define HSCP_OE_ONE 4'h2
`define HSCP_OE_TWO 4'h3
`define HSCP_OE_FOUR 4'hf

// bits moved per serial clock edge
`define HSCP_STEP_ONE 4'h1
`define HSCP_STEP_TWO 4'h2
`define HSCP_STEP_FOUR 4'h4

// transaction header: top two bits of the first address byte
`define HSCP_HDR_WRITE 2'b10
`define HSCP_ADDR_LAST 2'h2

// memory map: queue page and register page
`define HSCP_QUEUE_PAGE 10'h000
`define HSCP_REG_PAGE 18'h00100
`define HSCP_REG_LANE_WIDTH 2'h0
`define HSCP_REG_CMD_WPTR 2'h1
`define HSCP_REG_CMD_RPTR 2'h2
`define HSCP_REG_INT_FLAG 2'h3
`define HSCP_BYTE_LO 2'h0
`define HSCP_BYTE_HI 2'h1

// command queue, 4 Kbyte
`define HSCP_QUEUE_BYTES 4096
`define HSCP_WORD_BYTES 12'h004
`define HSCP_TIMED_BYTES 12'h008
`define HSCP_OP_TIMED 32'hffffff43

// timing
`define HSCP_CLK_NS 8
`define HSCP_MS_NS 1000000
`define HSCP_MS_CYCLES (`HSCP_MS_NS / `HSCP_CLK_NS)

// command buffer
`define HSCP_CMD_W 32
`define HSCP_FIFO_DEPTH 8
`define HSCP_FIFO_AW 3

`endif

// >>> src/hscp_fifo.v
// small flip-flop fifo with valid/ready on both sides
module hscp_fifo #(
  parameter W = 32,
  parameter D = 8,
  parameter AW = 3
) (
  // system
  input wire clk_sys,
  input wire resetn,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // full and empty straight from the occupancy count
  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];

  // pointers wrap at the depth, which need not be a power of two
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // storage is not reset; only written slots are ever read
  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule

// >>> src/hscp_top.v
// host serial command port: serial target, command queue and engine
`include "hscp_defs.vh"

module hscp_top #(
  parameter MS_CYCLES = `HSCP_MS_CYCLES
) (
  // system
  input wire clk_sys,
  input wire resetn,
  // host link, select active low
  input wire sclk,
  input wire cs_n,
  input wire data_lane_0_i,
  output wire data_lane_0_o,
  output wire data_lane_0_oe,
  input wire data_lane_1_i,
  output wire data_lane_1_o,
  output wire data_lane_1_oe,
  input wire data_lane_2_i,
  output wire data_lane_2_o,
  output wire data_lane_2_oe,
  input wire data_lane_3_i,
  output wire data_lane_3_o,
  output wire data_lane_3_oe,
  // interrupt to host, active low
  output wire int_n,
  // command execution side
  output wire cmd_valid,
  output wire [31:0] cmd_data,
  input wire cmd_ready
);

  localparam PH_ADDR = 2'd0;
  localparam PH_DUMMY = 2'd1;
  localparam PH_RDATA = 2'd2;
  localparam PH_WDATA = 2'd3;
  localparam EN_RUN = 1'b0;
  localparam EN_TIME = 1'b1;

  // queue storage: flip-flops indexed by byte address
  reg [7:0] mem_q [0:`HSCP_QUEUE_BYTES-1];

  reg [5:0] s1_q;
  reg [5:0] s2_q;
  reg sclk_prev_q;
  reg [1:0] width_q;
  reg [1:0] width_pend_q;
  reg [1:0] phase_q;
  reg [1:0] cnt_q;
  reg [3:0] bit_q;
  reg [7:0] in_sh_q;
  reg [7:0] out_sh_q;
  reg [21:0] addr_q;
  reg [3:0] lane_out_q;
  reg [3:0] lane_oe_q;
  reg [7:0] wlo_q;
  reg [11:0] wptr_q;
  reg [11:0] fptr_q;
  reg [11:0] rptr_q;
  reg en_st_q;
  reg [31:0] ms_left_q;
  reg [31:0] cyc_q;
  reg int_flag_q;

  // bits per serial clock edge for a width code
  function [3:0] lane_step(input [1:0] w);
    case (w)
      `HSCP_WIDTH_TWO: lane_step = `HSCP_STEP_TWO;
      `HSCP_WIDTH_FOUR: lane_step = `HSCP_STEP_FOUR;
      default: lane_step = `HSCP_STEP_ONE;
    endcase
  endfunction

  // lane order puts the higher bit on the higher lane
  function [7:0] shift_in(input [7:0] sh, input [1:0] w, input [3:0] l);
    case (w)
      `HSCP_WIDTH_TWO: shift_in = {sh[5:0], l[1:0]};
      `HSCP_WIDTH_FOUR: shift_in = {sh[3:0], l};
      default: shift_in = {sh[6:0], l[0]};
    endcase
  endfunction

  function [7:0] shift_out(input [7:0] sh, input [1:0] w);
    case (w)
      `HSCP_WIDTH_TWO: shift_out = {sh[5:0], 2'b00};
      `HSCP_WIDTH_FOUR: shift_out = {sh[3:0], 4'h0};
      default: shift_out = {sh[6:0], 1'b0};
    endcase
  endfunction

  // single lane answers on lane 1 only
  function [3:0] drive_map(input [7:0] sh, input [1:0] w);
    case (w)
      `HSCP_WIDTH_TWO: drive_map = {2'b00, sh[7:6]};
      `HSCP_WIDTH_FOUR: drive_map = sh[7:4];
      default: drive_map = {2'b00, sh[7], 1'b0};
    endcase
  endfunction

  function [3:0] oe_map(input [1:0] w);
    case (w)
      `HSCP_WIDTH_TWO: oe_map = `HSCP_OE_TWO;
      `HSCP_WIDTH_FOUR: oe_map = `HSCP_OE_FOUR;
      default: oe_map = `HSCP_OE_ONE;
    endcase
  endfunction

  function is_reg(input [21:0] a);
    is_reg = (a[21:4] == `HSCP_REG_PAGE);
  endfunction

  // byte seen by a host read at address a; unmapped space reads zero
  function [7:0] rd_byte(input [21:0] a);
    reg [31:0] word;
    begin
      case (a[3:2])
        `HSCP_REG_LANE_WIDTH: word = {30'h0, width_q};
        `HSCP_REG_CMD_WPTR: word = {20'h0, wptr_q};
        `HSCP_REG_CMD_RPTR: word = {20'h0, rptr_q};
        default: word = {31'h0, int_flag_q};
      endcase
      if (a[21:12] == `HSCP_QUEUE_PAGE) begin
        rd_byte = mem_q[a[11:0]];
      end else if (is_reg(a)) begin
        rd_byte = word[{a[1:0], 3'b000} +: 8];
      end else begin
        rd_byte = 8'h00;
      end
    end
  endfunction

  // pins come from the host's domain: two flops before any use
  wire [5:0] pins = {cs_n, sclk, data_lane_3_i, data_lane_2_i,
                     data_lane_1_i, data_lane_0_i};
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 6'h30;
      s2_q <= 6'h30;
      sclk_prev_q <= 1'b1;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[4];
    end
  end

  wire [3:0] lane_s = s2_q[3:0];
  wire active = ~s2_q[5];
  wire sclk_rise = s2_q[4] & ~sclk_prev_q & active;
  wire [7:0] in_next = shift_in(in_sh_q, width_q, lane_s);
  wire [3:0] bit_nx = bit_q + lane_step(width_q);
  wire byte_done = bit_nx[3];
  wire [23:0] hdr = {addr_q[15:0], in_next};
  wire out_load = sclk_rise & byte_done &
                  (phase_q == PH_DUMMY || phase_q == PH_RDATA);
  wire out_shift = sclk_rise & ~byte_done & (phase_q == PH_RDATA);
  wire wr_byte = sclk_rise & byte_done & (phase_q == PH_WDATA);
  wire int_clr = out_load & is_reg(addr_q) &
                 (addr_q[3:2] == `HSCP_REG_INT_FLAG);
  wire [7:0] out_sh_d = out_load ? rd_byte(addr_q) :
                        out_shift ? shift_out(out_sh_q, width_q) : out_sh_q;

  // frame decode: three address bytes, then data or a dummy and data
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_q <= PH_ADDR;
      cnt_q <= 2'h0;
      bit_q <= 4'h0;
      in_sh_q <= 8'h00;
      addr_q <= 22'h0;
      lane_oe_q <= `HSCP_OE_NONE;
    end else if (!active) begin
      phase_q <= PH_ADDR;
      cnt_q <= 2'h0;
      bit_q <= 4'h0;
      lane_oe_q <= `HSCP_OE_NONE;
    end else if (sclk_rise) begin
      in_sh_q <= in_next;
      bit_q <= byte_done ? 4'h0 : bit_nx;
      if (byte_done) begin
        case (phase_q)
          PH_ADDR: begin
            addr_q <= hdr[21:0];
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == `HSCP_ADDR_LAST) begin
              phase_q <= (hdr[23:22] == `HSCP_HDR_WRITE) ? PH_WDATA :
                         PH_DUMMY;
            end
          end
          PH_DUMMY: begin
            addr_q <= addr_q + 1'b1;
            phase_q <= PH_RDATA;
            lane_oe_q <= oe_map(width_q);
          end
          default: begin
            addr_q <= addr_q + 1'b1;
          end
        endcase
      end
    end
  end

  // answer data is held in flops; lanes change just after a rising edge
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_sh_q <= 8'h00;
      lane_out_q <= 4'h0;
    end else begin
      out_sh_q <= out_sh_d;
      lane_out_q <= drive_map(out_sh_d, width_q);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      wire [1:0] pad = {lane_out_q[gi], lane_oe_q[gi]};
    end
  endgenerate
  assign data_lane_0_o = g_lane[0].pad[1];
  assign data_lane_0_oe = g_lane[0].pad[0];
  assign data_lane_1_o = g_lane[1].pad[1];
  assign data_lane_1_oe = g_lane[1].pad[0];
  assign data_lane_2_o = g_lane[2].pad[1];
  assign data_lane_2_oe = g_lane[2].pad[0];
  assign data_lane_3_o = g_lane[3].pad[1];
  assign data_lane_3_oe = g_lane[3].pad[0];

  // register writes; width is staged so a frame never changes width midway
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      width_q <= `HSCP_LANE_WIDTH_RST;
      width_pend_q <= `HSCP_LANE_WIDTH_RST;
      wlo_q <= 8'h00;
      wptr_q <= 12'h000;
    end else begin
      if (!active) begin
        width_q <= width_pend_q;
      end
      if (wr_byte && is_reg(addr_q)) begin
        case (addr_q[3:2])
          `HSCP_REG_LANE_WIDTH: begin
            if (addr_q[1:0] == `HSCP_BYTE_LO &&
                in_next[1:0] != `HSCP_WIDTH_RSVD) begin
              width_pend_q <= in_next[1:0];
            end
          end
          `HSCP_REG_CMD_WPTR: begin
            // pointer moves only when its high byte lands
            if (addr_q[1:0] == `HSCP_BYTE_LO) begin
              wlo_q <= in_next;
            end else if (addr_q[1:0] == `HSCP_BYTE_HI) begin
              wptr_q <= {in_next[3:0], wlo_q};
            end
          end
          default: begin
            wlo_q <= wlo_q;
          end
        endcase
      end
    end
  end

  // queue bytes written by the host; no reset on bulk storage
  always @(posedge clk_sys) begin
    if (wr_byte && addr_q[21:12] == `HSCP_QUEUE_PAGE) begin
      mem_q[addr_q[11:0]] <= in_next;
    end
  end

  // engine fetch: whole words at the fetch pointer, wrapping at 4 Kbyte
  wire [11:0] avail = wptr_q - fptr_q;
  wire [31:0] word0 = {mem_q[fptr_q + 12'd3], mem_q[fptr_q + 12'd2],
                       mem_q[fptr_q + 12'd1], mem_q[fptr_q]};
  wire [31:0] word1 = {mem_q[fptr_q + 12'd7], mem_q[fptr_q + 12'd6],
                       mem_q[fptr_q + 12'd5], mem_q[fptr_q + 12'd4]};
  wire is_timed = (word0 == `HSCP_OP_TIMED);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire push = (en_st_q == EN_RUN) & (avail >= `HSCP_WORD_BYTES) &
              ~is_timed & fifo_in_ready;
  // timed command waits until everything before it has executed
  wire timed_go = (en_st_q == EN_RUN) & is_timed &
                  (avail >= `HSCP_TIMED_BYTES) & (rptr_q == fptr_q);
  wire pop = fifo_out_valid & cmd_ready;
  wire ms_tick = (cyc_q == MS_CYCLES - 1);
  wire timed_done = (en_st_q == EN_TIME) & (ms_left_q == 32'h0);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_st_q <= EN_RUN;
      fptr_q <= 12'h000;
      rptr_q <= 12'h000;
      ms_left_q <= 32'h0;
      cyc_q <= 32'h0;
    end else begin
      case (en_st_q)
        EN_RUN: begin
          if (push) begin
            fptr_q <= fptr_q + `HSCP_WORD_BYTES;
          end else if (timed_go) begin
            fptr_q <= fptr_q + `HSCP_TIMED_BYTES;
            ms_left_q <= word1;
            cyc_q <= 32'h0;
            en_st_q <= EN_TIME;
          end
          if (pop) begin
            rptr_q <= rptr_q + `HSCP_WORD_BYTES;
          end
        end
        EN_TIME: begin
          // millisecond enable from a divider on the system clock
          if (timed_done) begin
            rptr_q <= rptr_q + `HSCP_TIMED_BYTES;
            en_st_q <= EN_RUN;
          end else if (ms_tick) begin
            cyc_q <= 32'h0;
            ms_left_q <= ms_left_q - 1'b1;
          end else begin
            cyc_q <= cyc_q + 1'b1;
          end
        end
        default: begin
          en_st_q <= EN_RUN;
        end
      endcase
    end
  end

  // interrupt flag: a host read of it clears, a new event wins the clear
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      int_flag_q <= 1'b0;
    end else if (timed_done) begin
      int_flag_q <= 1'b1;
    end else if (int_clr) begin
      int_flag_q <= 1'b0;
    end
  end

  assign int_n = ~int_flag_q;

  // buffered hand-off; a stalled executor stops fetching via fifo_in_ready
  hscp_fifo #(
    .W(`HSCP_CMD_W),
    .D(`HSCP_FIFO_DEPTH),
    .AW(`HSCP_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(word0),
    .out_valid(fifo_out_valid),
    .out_ready(cmd_ready),
    .out_data(cmd_data)
  );

  assign cmd_valid = fifo_out_valid;

endmodule

// >>> verif/host_serial_command_port_tb.sv
// self-checking bench for the host serial command port
module host_serial_command_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
  logic clk_sys;
  logic resetn;
  logic cmd_ready;
  logic [31:0] rd;
  wire sclk, cs_n, int_n, cmd_valid;
  wire [31:0] cmd_data;
  wire [3:0] drv, lo, oe, lane;
  int num_errors;
  int n_compared;
  // wire level: device wins where it drives, otherwise the host
  assign lane = (oe & lo) | (~oe & drv);
  hscp_top #(.MS_CYCLES(MS)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
    .sclk(sclk), .cs_n(cs_n), .data_lane_0_i(lane[0]), .data_lane_0_o(lo[0]),
    .data_lane_0_oe(oe[0]), .data_lane_1_i(lane[1]), .data_lane_1_o(lo[1]),
    .data_lane_1_oe(oe[1]), .data_lane_2_i(lane[2]), .data_lane_2_o(lo[2]),
    .data_lane_2_oe(oe[2]), .data_lane_3_i(lane[3]), .data_lane_3_o(lo[3]),
    .data_lane_3_oe(oe[3]), .int_n(int_n), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready));
  hscp_host_model i_host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
    .drv(drv), .lane(lane));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait for a command word or the interrupt
  task automatic wait_on(input bit irq, input int lim, output int t);
    t = 0;
    while ((irq ? int_n : ~cmd_valid) !== 1'b0 && t < lim) begin
      @(posedge clk_sys);
      #1;
      t++;
    end
    if (t == lim) begin
      num_errors++;
      $display("BAD wait expected event seen timeout");
      wrap_up();
    end
  endtask
  task automatic wr(input logic [21:0] a, input logic [31:0] d, input int nb);
    i_host.frame({2'b10, a}, d, nb, rd);
  endtask
  task automatic rdr(input logic [21:0] a, input int nb);
    i_host.frame({2'b00, a}, 32'h0, nb, rd);
  endtask
  // idle pins, one lane and an empty queue out of reset
  task automatic t_reset();
    check("lane_oe", {28'h0, oe}, 32'h0);
    check("int_n", {31'h0, int_n}, 32'h1);
    check("cmd_valid", {31'h0, cmd_valid}, 32'h0);
    rdr(22'h001000, 1);
    check("lane_width", rd, 32'h0);
    rdr(22'h001008, 2);
    check("read_ptr", rd, 32'h0);
    $display("test reset done");
  endtask
  // every width code, reserved included, read back in the new width
  task automatic t_width();
    logic [1:0] cur;
    cur = 2'b00;
    for (int c = 1; c < 5; c++) begin
      wr(22'h001000, 32'(c & 3), 1);
      if (2'(c) != 2'b11) cur = 2'(c);
      i_host.width_q = cur;
      rdr(22'h001000, 1);
      check("lane_width", rd, {30'h0, cur});
    end
    // reset in mid-run must bring the link back to one lane
    wr(22'h001000, 32'h1, 1);
    resetn = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    i_host.width_q = 2'b00;
    check("lane_oe", {28'h0, oe}, 32'h0);
    rdr(22'h001000, 1);
    check("lane_width", rd, 32'h0);
    $display("test width done");
  endtask
  // executor stalls while nine words queue up, then drains them in order
  task automatic t_queue();
    int t;
    cmd_ready = 1'b0;
    for (int k = 0; k < 9; k++) wr(22'(4 * k), 32'h1000_0000 + k, 4);
    wr(22'h001004, 32'h24, 2);
    wait_on(1'b0, 50, t);
    rdr(22'h001008, 2);
    check("read_ptr", rd, 32'h0);
    for (int k = 0; k < 9; k++) begin
      wait_on(1'b0, 50, t);
      check("cmd_data", cmd_data, 32'h1000_0000 + k);
      cmd_ready = 1'b1;
      @(posedge clk_sys);
      #1;
      cmd_ready = 1'b0;
      // let an edge pass so ready never drops and rises in one step
      @(posedge clk_sys);
      #1;
      if (k == 0) begin
        rdr(22'h001008, 2);
        check("read_ptr", rd, 32'h4);
      end
    end
    rdr(22'h001008, 2);
    check("read_ptr", rd, 32'h24);
    check("cmd_valid", {31'h0, cmd_valid}, 32'h0);
    // queue bytes read back over the link; host cannot move the read pointer
    rdr(22'h000020, 4);
    check("queue_word", rd, 32'h1000_0008);
    wr(22'h001008, 32'h0, 2);
    rdr(22'h001008, 2);
    check("read_ptr", rd, 32'h24);
    $display("test queue done");
  endtask
  // timed command of three units; reading the flag releases the line
  task automatic t_timer();
    int t;
    wr(22'h000024, 32'hffffff43, 4);
    wr(22'h000028, 32'h3, 4);
    wr(22'h001004, 32'h2c, 2);
    check("int_n", {31'h0, int_n}, 32'h1);
    wait_on(1'b1, 200, t);
    check("delay_ok", 32'(t >= 40 && t <= 60), 32'h1);
    rdr(22'h001008, 2);
    check("read_ptr", rd, 32'h2c);
    check("int_n", {31'h0, int_n}, 32'h0);
    rdr(22'h00100c, 1);
    check("int_n", {31'h0, int_n}, 32'h1);
    $display("test timer done");
  endtask
  initial begin
    resetn = 1'b0;
    cmd_ready = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_reset();
    t_width();
    t_queue();
    t_timer();
    wrap_up();
  end
endmodule

// >>> verif/hscp_host_model.sv
// host controller model driving the serial link
module hscp_host_model (
  // pacing clock
  input wire logic clk_sys,
  // link
  output logic sclk,
  output logic cs_n,
  output logic [3:0] drv,
  input wire logic [3:0] lane
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] width_q;
  // clock idles low between frames, select idles high
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 4'h0;
    width_q = 2'b00;
  end
  // half a bit step, 32 ns, keeps well inside the rate limit
  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  // one byte msb first; drive on fall, sample just before the rise
  task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
    int n;
    n = (width_q == 2'b00) ? 1 : (width_q == 2'b01) ? 2 : 4;
    r = 8'h00;
    for (int i = 8 - n; i >= 0; i -= n) begin
      // lanes outside the width idle high so a silent device reads as ones on one lane; wider reads see the 5a filler
      drv = 4'((b >> i) & ((1 << n) - 1)) | 4'(~((1 << n) - 1));
      half();
      r = (r << n) | 8'((n == 1) ? lane[1] : lane & 4'((1 << n) - 1));
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
  endtask
  // one transaction: address, dummy on reads, then nb data bytes
  task automatic frame(input logic [23:0] a, input logic [31:0] wd,
    input int nb, output logic [31:0] rd);
    logic [7:0] r;
    rd = 32'h0;
    cs_n = 1'b0;
    half();
    for (int k = 2; k >= 0; k--) xbyte(a[8 * k +: 8], r);
    if (!a[23]) xbyte(8'h00, r);
    for (int k = 0; k < nb; k++) begin
      xbyte(a[23] ? wd[8 * k +: 8] : 8'h5a, r);
      rd[8 * k +: 8] = r;
    end
    half();
    cs_n = 1'b1;
    drv = ~drv; // released lines must not keep a stale level
    half();
    half();
  endtask
endmodule

// >>> verif/hscp_top_chk.sv
// pin-level assertions for the host serial command port
module hscp_top_chk #(
  parameter MS_CYCLES = 20
) (
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // link select and lane enables
  input wire logic cs_n,
  input wire logic data_lane_0_oe,
  input wire logic data_lane_1_oe,
  input wire logic data_lane_2_oe,
  input wire logic data_lane_3_oe,
  // interrupt and command side
  input wire logic int_n,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_data,
  input wire logic cmd_ready
);
  logic [3:0] oe;
  logic [3:0] hi_q;
  assign oe = {data_lane_3_oe, data_lane_2_oe, data_lane_1_oe, data_lane_0_oe};
  // cycles select has been high; saturates so it never wraps to zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) hi_q <= 4'h0;
    else if (!cs_n) hi_q <= 4'h0;
    else if (hi_q != 4'hf) hi_q <= hi_q + 4'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_oe_legal: assert property (oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("lane enables form an illegal mask");
  a_oe_off_idle: assert property (hi_q > 4'h5 |-> oe == 4'h0)
    else $error("lanes driven while deselected");
  a_oe_quiet_start: assert property ($fell(cs_n) |-> (oe == 4'h0) [*8])
    else $error("lanes driven during address phase");
  a_oe_hold_frame: assert property (oe != 4'h0 && !cs_n |=> $stable(oe))
    else $error("lane enables changed inside a frame");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_data))
    else $error("command word changed before pop");
  a_pop_only: assert property ($fell(cmd_valid) |-> $past(cmd_ready))
    else $error("command withdrawn without pop");
  a_int_stays: assert property (hi_q > 4'h5 && !int_n |=> !int_n)
    else $error("interrupt cleared without a flag read");
  a_int_order: assert property ($fell(int_n) |-> !cmd_valid)
    else $error("interrupt raised with later command pending");
  c_pop: cover property (cmd_valid && cmd_ready);
  c_int: cover property ($fell(int_n));
  c_quad: cover property (oe == 4'hf);
endmodule

bind hscp_top hscp_top_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.clk_sys, .resetn,
  .cs_n, .data_lane_0_oe, .data_lane_1_oe, .data_lane_2_oe, .data_lane_3_oe,
  .int_n, .cmd_valid, .cmd_data, .cmd_ready);
